/* File: pkg/gcgr_defs.svh */
`ifndef GCGR_DEFS_SVH
`define GCGR_DEFS_SVH

// Printed offsets are register indices; byte address is four times the index.
`define GCGR_IDX_MODEM_SVC      8'h46
`define GCGR_IDX_REVISION       8'h4f
`define GCGR_IDX_CHAN_SEL       8'h68
`define GCGR_IDX_IO_DATA        8'h70
`define GCGR_IDX_IO_DIR         8'h71
`define GCGR_IDX_SVC_CTRL       8'h7e
`define GCGR_IDX_CMD            8'h7f

`define GCGR_RST_MODEM_SVC      8'h00
`define GCGR_RST_REVISION       8'h00
`define GCGR_RST_CHAN_SEL       8'h00
`define GCGR_RST_IO_DATA        8'h00
`define GCGR_RST_IO_DIR         8'h00

`define GCGR_CHAN_LO            0
`define GCGR_CHAN_HI            1
`define GCGR_CHAN_RSVD_BIT      2
`define GCGR_POLL_LO            3
`define GCGR_POLL_HI            7
`define GCGR_MSC_CHAN_LO        2
`define GCGR_MSC_CHAN_HI        3

`define GCGR_CMD_GLOBAL_RESET   8'h81

// Reset processing time in ns.
`define GCGR_RESET_TIME_NS      2000
`define GCGR_CLK_PERIOD_NS      10
`define GCGR_RESET_CYCLES       ((`GCGR_RESET_TIME_NS + `GCGR_CLK_PERIOD_NS - 1) / `GCGR_CLK_PERIOD_NS)

`endif

/* File: pkg/gcgr_pkg.sv */
package gcgr_pkg;

    typedef enum logic [1:0] {
        GCGR_ST_BUSY  = 2'b01,
        GCGR_ST_READY = 2'b10
    } gcgr_state_t;

    typedef logic [7:0] gcgr_byte_t;

endpackage : gcgr_pkg

/* File: verilog/gcgr_io_pin.sv */
`timescale 1ns/1ps
module gcgr_io_pin (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic dirBit,
    input  wire logic dataBit,
    input  wire logic pinIn,
    output logic      pinOut,
    output logic      pinOe,
    output logic      readBit
);
    logic pinOut_next;
    logic pinOe_next;
    logic readBit_next;

    always_comb begin
        pinOe_next   = dirBit;
        pinOut_next  = dataBit;
        readBit_next = dirBit ? dataBit : pinIn;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinOut  <= 1'b0;
            pinOe   <= 1'b0;
            readBit <= 1'b0;
        end else begin
            pinOut  <= pinOut_next;
            pinOe   <= pinOe_next;
            readBit <= readBit_next;
        end
    end
endmodule : gcgr_io_pin

/* File: verilog/gcgr_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - Channel select bits 1:0 pick channel 0, 2 or 3; code 01 unused.
// - Upper five channel select bits ignored except as poll-mode context.
// - Revision register normally reads the 8-bit firmware revision code.
// - Power-on or software global reset clears the revision register to zero.
// - Revision code reloads once reset processing ends; nonzero means ready.
// - Direction bit one makes the matching pin output, zero makes input.
// - Data bit n maps to general-purpose pin n across eight pins.
// - Written data drives unchanged onto every pin set as output.
// - Data reads give live level for inputs, written value for outputs.
// - Modem channel bits 3:2 show serviced channel during a service cycle.
// - Modem channel bits 7:4 and 1:0 read back as host wrote them.
`include "gcgr_defs.svh"
module gcgr_regs
    import gcgr_pkg::*;
#(
    parameter int         IO_WIDTH    = 8,
    parameter int         RESET_CYCLES = `GCGR_RESET_CYCLES,
    // Arbitrary neutral revision value.
    parameter logic [7:0] REVISION    = 8'h01
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [9:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic                     wb_err_o,
    input  wire logic                svcActive,
    input  wire logic [1:0]          svcChannel,
    input  wire logic [IO_WIDTH-1:0] gpIn,
    output logic      [IO_WIDTH-1:0] gpOut,
    output logic      [IO_WIDTH-1:0] gpOe,
    output logic      [1:0]          channelSel,
    output logic      [4:0]          pollContext,
    output logic                     hostReady
);
    gcgr_byte_t             chanSel_reg,   chanSel_next;
    gcgr_byte_t             revision_reg,  revision_next;
    gcgr_byte_t             modemSvc_reg,  modemSvc_next;
    logic [IO_WIDTH-1:0]    ioData_reg,    ioData_next;
    logic [IO_WIDTH-1:0]    ioDir_reg,     ioDir_next;
    logic [15:0]            rstCnt_reg,    rstCnt_next;
    gcgr_state_t            state_reg,     state_next;
    logic [31:0]            datOut_reg,    datOut_next;
    logic                   ack_reg,       ack_next;
    logic                   err_reg,       err_next;
    logic [1:0]             chanOut_reg;
    logic [4:0]             pollOut_reg;
    logic                   ready_reg;
    logic [IO_WIDTH-1:0]    ioRead;
    logic [7:0]             idx;
    logic                   req;
    logic                   wr;
    logic                   mapped;
    gcgr_byte_t             rdByte;
    gcgr_byte_t             modemView;

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign wr  = req && wb_we_i && wb_sel_i[0];

    genvar gi;
    generate
        for (gi = 0; gi < IO_WIDTH; gi++) begin : g_pin
            gcgr_io_pin u_pin (
                .clk     (clk),
                .arst_n  (arst_n),
                .dirBit  (ioDir_reg[gi]),
                .dataBit (ioData_reg[gi]),
                .pinIn   (gpIn[gi]),
                .pinOut  (gpOut[gi]),
                .pinOe   (gpOe[gi]),
                .readBit (ioRead[gi])
            );
        end
    endgenerate

    always_comb begin
        modemView = modemSvc_reg;
        if (svcActive) begin
            modemView[`GCGR_MSC_CHAN_HI:`GCGR_MSC_CHAN_LO] = svcChannel;
        end
        mapped = 1'b1;
        case (idx)
            `GCGR_IDX_CHAN_SEL:  rdByte = chanSel_reg;
            `GCGR_IDX_REVISION:  rdByte = revision_reg;
            `GCGR_IDX_MODEM_SVC: rdByte = modemView;
            `GCGR_IDX_IO_DATA:   rdByte = 8'(ioRead);
            `GCGR_IDX_IO_DIR:    rdByte = 8'(ioDir_reg);
            `GCGR_IDX_SVC_CTRL:  rdByte = {7'h00, state_reg == GCGR_ST_READY};
            `GCGR_IDX_CMD:       rdByte = 8'h00;
            default: begin
                rdByte = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        chanSel_next  = chanSel_reg;
        revision_next = revision_reg;
        modemSvc_next = modemSvc_reg;
        ioData_next   = ioData_reg;
        ioDir_next    = ioDir_reg;
        rstCnt_next   = rstCnt_reg;
        state_next    = state_reg;
        datOut_next   = 32'h0000_0000;
        ack_next      = req && mapped;
        err_next      = req && !mapped;
        if (req && mapped && !wb_we_i) begin
            datOut_next = {24'h00_0000, rdByte};
        end
        if (wr && state_reg == GCGR_ST_READY) begin
            case (idx)
                `GCGR_IDX_CHAN_SEL:  chanSel_next = wb_dat_i[7:0];
                `GCGR_IDX_REVISION:  revision_next = wb_dat_i[7:0];
                `GCGR_IDX_MODEM_SVC: modemSvc_next = wb_dat_i[7:0];
                `GCGR_IDX_IO_DATA:   ioData_next = wb_dat_i[IO_WIDTH-1:0];
                `GCGR_IDX_IO_DIR:    ioDir_next = wb_dat_i[IO_WIDTH-1:0];
                `GCGR_IDX_CMD: begin
                    if (wb_dat_i[7:0] == `GCGR_CMD_GLOBAL_RESET) begin
                        revision_next = `GCGR_RST_REVISION;
                        rstCnt_next   = 16'h0000;
                        state_next    = GCGR_ST_BUSY;
                    end
                end
                default: ;
            endcase
        end
        case (state_reg)
            GCGR_ST_BUSY: begin
                rstCnt_next = rstCnt_reg + 16'h0001;
                if (rstCnt_reg >= 16'(RESET_CYCLES - 1)) begin
                    revision_next = REVISION;
                    state_next    = GCGR_ST_READY;
                end
            end
            GCGR_ST_READY: ;
            default: state_next = GCGR_ST_BUSY;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chanSel_reg  <= `GCGR_RST_CHAN_SEL;
            revision_reg <= `GCGR_RST_REVISION;
            modemSvc_reg <= `GCGR_RST_MODEM_SVC;
            ioData_reg   <= IO_WIDTH'(`GCGR_RST_IO_DATA);
            ioDir_reg    <= IO_WIDTH'(`GCGR_RST_IO_DIR);
            rstCnt_reg   <= 16'h0000;
            state_reg    <= GCGR_ST_BUSY;
            datOut_reg   <= 32'h0000_0000;
            ack_reg      <= 1'b0;
            err_reg      <= 1'b0;
            chanOut_reg  <= 2'b00;
            pollOut_reg  <= 5'h00;
            ready_reg    <= 1'b0;
        end else begin
            chanSel_reg  <= chanSel_next;
            revision_reg <= revision_next;
            modemSvc_reg <= modemSvc_next;
            ioData_reg   <= ioData_next;
            ioDir_reg    <= ioDir_next;
            rstCnt_reg   <= rstCnt_next;
            state_reg    <= state_next;
            datOut_reg   <= datOut_next;
            ack_reg      <= ack_next;
            err_reg      <= err_next;
            chanOut_reg  <= chanSel_next[`GCGR_CHAN_HI:`GCGR_CHAN_LO];
            pollOut_reg  <= chanSel_next[`GCGR_POLL_HI:`GCGR_POLL_LO];
            ready_reg    <= state_next == GCGR_ST_READY;
        end
    end

    // Writes during reset processing are acknowledged but dropped, since the device is not yet accepting host writes; reads are still answered.
    assign wb_dat_o    = datOut_reg;
    assign wb_ack_o    = ack_reg;
    assign wb_err_o    = err_reg;
    assign channelSel  = chanOut_reg;
    assign pollContext = pollOut_reg;
    assign hostReady   = ready_reg;
endmodule : gcgr_regs

/* File: tb/gcgr_pin_model.sv */
`timescale 1ns/1ps
module gcgr_pin_model
    import gcgr_pkg::*;
#(parameter int W = 8) (
    input  wire logic [W-1:0] gpOut,
    input  wire logic [W-1:0] gpOe,
    input  wire logic [W-1:0] extLevel,
    output logic      [W-1:0] gpIn
);
    // pin resolution
    // A released pin shows the outside level, never a stale driven value.
    assign gpIn = (gpOe & gpOut) | (~gpOe & extLevel);
endmodule : gcgr_pin_model

/* File: tb/gcgr_regs_sva.sv */
`timescale 1ns/1ps
module gcgr_regs_sva
    import gcgr_pkg::*;
#(parameter int IO_WIDTH = 8) (
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic [9:0]          wb_adr_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic                wb_we_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic                wb_err_o,
    input wire logic                svcActive,
    input wire logic [1:0]          svcChannel,
    input wire logic [IO_WIDTH-1:0] gpOut,
    input wire logic [IO_WIDTH-1:0] gpOe,
    input wire logic [1:0]          channelSel,
    input wire logic [4:0]          pollContext,
    input wire logic                hostReady
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence wrAck(logic [7:0] idx);
        wb_ack_o && wb_we_i && wb_sel_i[0] && $past(hostReady) && wb_adr_i[9:2] == idx;
    endsequence
    a_ack_answer: assert property (take |=> wb_ack_o || wb_err_o) else $error("request not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    a_dir_to_oe:
        assert property (wrAck(8'h71) |=> ##[0:1] gpOe == $past(wb_dat_i[7:0])) else $error("direction not applied");
    a_data_to_pin:
        assert property (wrAck(8'h70) |=> ##[0:1] (gpOut & gpOe) == ($past(wb_dat_i[7:0]) & gpOe))
        else $error("pin value differs");
    a_chan_write:
        assert property (wrAck(8'h68) |-> ##[0:2] {pollContext, channelSel} == {$past(wb_dat_i[7:3]),
            $past(wb_dat_i[1:0])}) else $error("channel select not stored");
    a_chan_hold:
        assert property ($changed(channelSel) |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
        else $error("channel select changed without write");
    a_ready_drop:
        assert property ($fell(hostReady) |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
        else $error("ready dropped without reset command");
    a_modem_chan:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h46 && svcActive && $past(svcActive)
            |-> wb_dat_o[3:2] == $past(svcChannel)) else $error("serviced channel wrong");
endmodule : gcgr_regs_sva
bind gcgr_regs gcgr_regs_sva #(.IO_WIDTH(IO_WIDTH)) i_gcgr_regs_sva (.*);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench
    import gcgr_pkg::*;
;
    // Arbitrary revision value.
    localparam gcgr_byte_t REV = 8'h3c;
    logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, svcActive = 1'b0, e;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [1:0] svcChannel = 2'h0, chSel;
    logic [7:0] ext = 8'h00, gpIn, gpOut, gpOe;
    logic [4:0] ctx;
    logic ack, err, ready;
    int bad_count = 0, comparisons = 0;
    always #5 clk = ~clk;
    gcgr_regs #(.RESET_CYCLES(4), .REVISION(REV)) i_gcgr_regs (.clk(clk), .arst_n(arst_n), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .svcActive(svcActive), .svcChannel(svcChannel), .gpIn(gpIn),
        .gpOut(gpOut), .gpOe(gpOe), .channelSel(chSel), .pollContext(ctx), .hostReady(ready));
    gcgr_pin_model i_gcgr_pin_model (.gpOut(gpOut), .gpOe(gpOe), .extLevel(ext), .gpIn(gpIn));
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            wrap_up();
        end else begin
            q = rdat;
            e = err;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask : xfer
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(q, {24'h0, exp});
    endtask : rd
    task automatic waitReady;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            bad_count++;
            wrap_up();
        end
    endtask : waitReady
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h4f, 8'h00);
        waitReady();
        rd(8'h4f, REV);
        rd(8'h71, 8'h00);
        rd(8'h46, 8'h00);
        for (int c = 0; c < 4; c++) begin
            if (c != 1) begin
                xfer(1'b1, 8'h68, {5'h15, 1'b0, c[1:0]});
                chk({30'h0, chSel}, {30'h0, c[1:0]});
                chk({27'h0, ctx}, 32'h15);
            end
        end
        xfer(1'b1, 8'h71, 8'h0f);
        xfer(1'b1, 8'h70, 8'ha5);
        ext <= 8'h3c;
        repeat (3) @(posedge clk);
        chk({24'h0, gpOe}, 32'h0f);
        chk({24'h0, gpOut & gpOe}, 32'h05);
        rd(8'h70, 8'h35);
        rd(8'h68, 8'hab);
        xfer(1'b1, 8'h46, 8'hf3);
        rd(8'h46, 8'hf3);
        svcActive <= 1'b1;
        svcChannel <= 2'h2;
        rd(8'h46, 8'hfb);
        svcActive <= 1'b0;
        xfer(1'b0, 8'h00, 8'h00);
        chk({31'h0, e}, 32'h1);
        xfer(1'b1, 8'h7f, 8'h81);
        rd(8'h4f, 8'h00);
        waitReady();
        rd(8'h4f, REV);
        // A second power-on reset while ready must clear the revision again.
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h4f, 8'h00);
        rd(8'h71, 8'h00);
        waitReady();
        rd(8'h4f, REV);
        wrap_up();
    end
endmodule : testbench
